// file: spio_board.sv
// Purpose: board side of the pins for the port bench
// Assumes: released pins are pulled up unless the board drives them
// Notes: pin_in is registered, so it lags the pins by one cycle
`timescale 1ns/1ns
module spio_board (
   input wire logic aclk,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_n,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pin_in
);
   // the board drives only released pins, so there is never a fight
   always_ff @(posedge aclk) begin
      pin_in <= (~pin_oe_n & pin_out) | (pin_oe_n & (~ext_en | ext_val));
   end
endmodule

// file: spio_pin_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: one clock, synchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module spio_pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [spio_pkg::PORT_W-1:0] d,
   output logic [spio_pkg::PORT_W-1:0] q
);
   import spio_pkg::*;
   logic [PORT_W-1:0] meta_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// file: spio_pkg.sv
// Purpose: shared constants for the shared parallel io port
// Assumes: 16-bit port, 32-bit axi4-lite data, word-aligned registers
// Notes: bits above the port width read as zero
package spio_pkg;
   localparam int PORT_W = 16;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFF_DIRECTION = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_OUT_LATCH = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_PIN_VALUE = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_OPEN_DRAIN = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_ANALOG_CFG = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_ADC_DISABLE = 6'h14;
   localparam logic [PORT_W-1:0] RST_DIRECTION = 16'hffff;
   localparam logic [PORT_W-1:0] RST_OUT_LATCH = 16'h0000;
   localparam logic [PORT_W-1:0] RST_OPEN_DRAIN = 16'h0000;
   localparam logic [PORT_W-1:0] RST_ANALOG_CFG = 16'h0000;
   localparam logic RST_ADC_DISABLE = 1'b0;
   localparam int ADC_DIS_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: spio_port.sv
// Purpose: shared parallel io port with axi4-lite register access
// Assumes: pin and peripheral inputs synchronous to aclk; valid_mask and analog_capable_mask are strap constants
// Notes: pin drive is two signals per pin (pin_out, pin_oe_n), output enable active low
`timescale 1ns/1ns
// What this block does
// - a peripheral actively driving a pin takes the driver; pin still readable
// - an enabled but idle peripheral leaves the pin to the port
// - muxes pick owner; port output never loops into peripheral input
// - direction bit 1 makes an input, 0 an output
// - every pin is an input after reset
// - latch register reads and writes the latch
// - pin value register reads pins; writing it writes the latch
// - invalid bits are disabled and read zero in all registers
// - open-drain bit makes the pin open-drain instead of push-pull
// - analog configuration resets to zero, analog-capable pins start analog
// - analog pins read low in the pin value register
// - digital-configured pins pass no analog level to the converter
// - input-only shared pins stay plain port pins
// - converter disabled forces all pins digital
module spio_port #(
   parameter logic [15:0] VALID_MASK = 16'hffff,
   parameter logic [15:0] ANALOG_MASK = 16'h00ff
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [spio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [spio_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [spio_pkg::PORT_W-1:0] pin_in,
   output logic [spio_pkg::PORT_W-1:0] pin_out,
   output logic [spio_pkg::PORT_W-1:0] pin_oe_n,
   input wire logic [spio_pkg::PORT_W-1:0] periph_enable,
   input wire logic [spio_pkg::PORT_W-1:0] periph_drive,
   input wire logic [spio_pkg::PORT_W-1:0] periph_out,
   input wire logic [spio_pkg::PORT_W-1:0] periph_od,
   output logic [spio_pkg::PORT_W-1:0] periph_in,
   output logic [spio_pkg::PORT_W-1:0] analog_select
);
   import spio_pkg::*;

   logic [PORT_W-1:0] direction_r;
   logic [PORT_W-1:0] out_latch_r;
   logic [PORT_W-1:0] open_drain_r;
   logic [PORT_W-1:0] analog_cfg_r;
   logic adc_disable_r;
   logic [PORT_W-1:0] pin_sync;
   logic [PORT_W-1:0] analog_mode;
   logic [PORT_W-1:0] pin_value;
   logic [PORT_W-1:0] periph_own;
   logic [PORT_W-1:0] drv_val;
   logic [PORT_W-1:0] drv_od;
   logic [PORT_W-1:0] drv_en;
   logic [PORT_W-1:0] wmask;
   logic [PORT_W-1:0] wval;
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_write;
   logic wr_hit;

   spio_pin_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pin_in),
      .q(pin_sync)
   );

   // converter disable overrides the configuration bits
   assign analog_mode = ANALOG_MASK & VALID_MASK & ~analog_cfg_r & {PORT_W{~adc_disable_r}};
   assign pin_value = pin_sync & ~analog_mode & VALID_MASK;

   generate
      for (genvar i = 0; i < PORT_W; i++) begin : g_pin
         // ownership only while the peripheral is enabled and actively driving
         assign periph_own[i] = periph_enable[i] & periph_drive[i];
         assign drv_val[i] = periph_own[i] ? periph_out[i] : out_latch_r[i];
         assign drv_od[i] = periph_own[i] ? periph_od[i] : open_drain_r[i];
         assign drv_en[i] = VALID_MASK[i] & ~analog_mode[i] & (periph_own[i] | ~direction_r[i]);
      end
   endgenerate

   // pins driven by the port itself feed no peripheral input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_in <= '0;
      end else begin
         periph_in <= pin_sync & VALID_MASK & ~analog_mode & ~(~direction_r & ~periph_own);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_select <= '0;
      end else begin
         analog_select <= analog_mode;
      end
   end

   // open-drain drives only the low level; high is released
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out <= drv_val & ~drv_od;
         pin_oe_n <= ~(drv_en & ~(drv_od & drv_val));
      end
   end

   // write channel: address and data taken in either order
   assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wval = wdata_r[PORT_W-1:0];
   assign wr_hit = (awaddr_r == OFF_DIRECTION) | (awaddr_r == OFF_OUT_LATCH) | (awaddr_r == OFF_PIN_VALUE) |
                   (awaddr_r == OFF_OPEN_DRAIN) | (awaddr_r == OFF_ANALOG_CFG) | (awaddr_r == OFF_ADC_DISABLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         direction_r <= RST_DIRECTION;
         out_latch_r <= RST_OUT_LATCH;
         open_drain_r <= RST_OPEN_DRAIN;
         analog_cfg_r <= RST_ANALOG_CFG;
         adc_disable_r <= RST_ADC_DISABLE;
      end else if (do_write) begin
         case (awaddr_r)
            OFF_DIRECTION: direction_r <= ((direction_r & ~wmask) | (wval & wmask)) & VALID_MASK;
            OFF_OUT_LATCH, OFF_PIN_VALUE: begin
               out_latch_r <= ((out_latch_r & ~wmask) | (wval & wmask)) & VALID_MASK;
            end
            OFF_OPEN_DRAIN: open_drain_r <= ((open_drain_r & ~wmask) | (wval & wmask)) & VALID_MASK;
            OFF_ANALOG_CFG: analog_cfg_r <= ((analog_cfg_r & ~wmask) | (wval & wmask)) & VALID_MASK;
            OFF_ADC_DISABLE: begin
               if (wstrb_r[0]) begin
                  adc_disable_r <= wdata_r[ADC_DIS_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // read channel: one outstanding read, data from registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
               OFF_DIRECTION: s_axi_rdata <= {16'h0000, direction_r & VALID_MASK};
               OFF_OUT_LATCH: s_axi_rdata <= {16'h0000, out_latch_r & VALID_MASK};
               OFF_PIN_VALUE: s_axi_rdata <= {16'h0000, pin_value};
               OFF_OPEN_DRAIN: s_axi_rdata <= {16'h0000, open_drain_r};
               OFF_ANALOG_CFG: s_axi_rdata <= {16'h0000, analog_cfg_r};
               OFF_ADC_DISABLE: s_axi_rdata <= {31'h00000000, adc_disable_r};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: spio_port_checker.sv
// Purpose: port-level checks of spio_port
// Assumes: the bench gives peripherals only valid, non-analog pins
// Notes: a pin is owned when its peripheral is enabled and driving
`timescale 1ns/1ns
module spio_port_checker #(
   parameter logic [15:0] VALID_MASK = 16'hffff,
   parameter logic [15:0] ANALOG_MASK = 16'h00ff
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_n,
   input wire logic [15:0] periph_enable,
   input wire logic [15:0] periph_drive,
   input wire logic [15:0] periph_out,
   input wire logic [15:0] periph_od,
   input wire logic [15:0] periph_in,
   input wire logic [15:0] analog_select
);
   logic [15:0] own_push;
   logic [15:0] own_od;
   assign own_push = periph_enable & periph_drive & ~periph_od & VALID_MASK & ~ANALOG_MASK;
   assign own_od = periph_enable & periph_drive & periph_od & VALID_MASK & ~ANALOG_MASK;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PERIPH_DRIVES: assert property ($past(aresetn) |->
      ((pin_oe_n | (pin_out ^ $past(periph_out))) & $past(own_push)) == 16'h0000) else $error("owned pin not driven");
   AST_PERIPH_OD: assert property ($past(aresetn) |->
      ((pin_oe_n ^ $past(periph_out)) & $past(own_od)) == 16'h0000) else $error("open-drain owned pin wrong");
   AST_RESET_INPUT: assert property (!$past(aresetn) |-> &pin_oe_n && pin_out == 16'h0000)
      else $error("pin driven after reset");
   AST_INVALID_QUIET: assert property (((~pin_oe_n | periph_in | analog_select) & ~VALID_MASK) == 16'h0000)
      else $error("invalid pin active");
   AST_ANALOG_SUBSET: assert property ((analog_select & ~(ANALOG_MASK & VALID_MASK)) == 16'h0000)
      else $error("analog select on digital-only pin");
   AST_ANALOG_RESET: assert property ($past(aresetn) && !$past(aresetn, 2) |->
      ##[1:2] analog_select == (ANALOG_MASK & VALID_MASK)) else $error("pins not analog after reset");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   cover property (|own_push);
   cover property (|own_od);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind spio_port spio_port_checker #(.VALID_MASK(VALID_MASK), .ANALOG_MASK(ANALOG_MASK)) i_chk (.*);

// file: testbench.sv
// Purpose: random and corner tests of spio_port
// Assumes: board pulls released pins high
// Notes: peripherals own non-analog pins only, pin 15 is invalid
`timescale 1ns/1ns
module testbench;
   import spio_pkg::*;
   localparam logic [15:0] VM = 16'h7fff;
   localparam logic [15:0] AM = 16'h00ff;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] pin_in, pin_out, pin_oe_n, periph_enable, periph_drive, periph_out, periph_od;
   logic [15:0] periph_in, analog_select, ext_en, ext_val, dir, lat, odc, acfg, adis;
   int fails, cmp_count, seed;
   spio_port #(.VALID_MASK(VM), .ANALOG_MASK(AM)) i_dut (.*);
   spio_board i_board (.*);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      #1000000;
      fails++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("compared %0d, mismatched %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axi_wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic axi_rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   function automatic logic [15:0] f_an();
      return AM & VM & ~acfg & ~{16{adis[0]}};
   endfunction
   function automatic logic [15:0] f_port();
      return ~(periph_enable & periph_drive) & VM & ~f_an() & ~dir;
   endfunction
   function automatic logic [15:0] f_oe();
      return ~((periph_enable & periph_drive & ~(periph_od & periph_out)) | (f_port() & ~(odc & lat)));
   endfunction
   function automatic logic [15:0] f_out();
      return (periph_enable & periph_drive & ~periph_od & periph_out) | (f_port() & ~odc & lat);
   endfunction
   function automatic logic [15:0] f_pin();
      return ((~f_oe() & f_out()) | (f_oe() & (~ext_en | ext_val))) & VM & ~f_an();
   endfunction
   task automatic check_all();
      repeat (6) @(posedge aclk);
      chk("pin_oe_n", {16'h0, f_oe()}, {16'h0, pin_oe_n});
      chk("pin_out", {16'h0, ~f_oe() & f_out()}, {16'h0, ~f_oe() & pin_out});
      chk("periph_in", {16'h0, f_pin() & ~f_port()}, {16'h0, periph_in});
      chk("analog_select", {16'h0, f_an()}, {16'h0, analog_select});
      axi_rd(OFF_PIN_VALUE, {16'h0, f_pin()}, RESP_OKAY);
      axi_rd(OFF_DIRECTION, {16'h0, dir & VM}, RESP_OKAY);
      axi_rd(OFF_OUT_LATCH, {16'h0, lat & VM}, RESP_OKAY);
   endtask
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      periph_enable <= 16'h0000;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      {dir, lat, odc, acfg, adis} = {16'hffff, 64'h0};
      check_all();
      axi_rd(OFF_ANALOG_CFG, 32'h0, RESP_OKAY);
      axi_rd(OFF_OPEN_DRAIN, 32'h0, RESP_OKAY);
      $display("reset test done");
   endtask
   task automatic rnd_step(input int i);
      @(posedge aclk);
      periph_enable <= 16'($random(seed)) & VM & ~AM;
      periph_drive <= 16'($random(seed));
      periph_out <= 16'($random(seed));
      periph_od <= 16'($random(seed));
      ext_en <= 16'($random(seed));
      ext_val <= 16'($random(seed));
      acfg = (i < 4) ? 16'h00ff : 16'($random(seed));
      adis = {15'h0, i % 5 == 4};
      dir = 16'($random(seed)) | (AM & ~acfg);
      odc = 16'($random(seed));
      lat = (i == 0) ? 16'hffff : 16'($random(seed));
      axi_wr(OFF_ANALOG_CFG, acfg, RESP_OKAY);
      axi_wr(OFF_ADC_DISABLE, adis, RESP_OKAY);
      axi_wr(OFF_DIRECTION, dir, RESP_OKAY);
      axi_wr(OFF_OPEN_DRAIN, odc, RESP_OKAY);
      axi_wr(i[0] ? OFF_PIN_VALUE : OFF_OUT_LATCH, lat, RESP_OKAY);
      check_all();
   endtask
   initial begin
      seed = 32'he85b8142;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0f;
      {periph_enable, periph_drive, periph_out, periph_od, ext_en, ext_val} = 96'h0;
      do_reset();
      axi_wr(6'h18, 16'h1234, RESP_SLVERR);
      axi_rd(6'h3c, 32'h0, RESP_SLVERR);
      $display("unmapped test done");
      // low-byte strobe only: the high byte of the latch must keep its reset value
      @(posedge aclk);
      s_axi_wstrb <= 4'h1;
      axi_wr(OFF_OUT_LATCH, 16'habcd, RESP_OKAY);
      axi_rd(OFF_OUT_LATCH, 32'h000000cd, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      $display("strobe test done");
      for (int i = 0; i < 40; i++) begin
         rnd_step(i);
      end
      $display("random test done");
      do_reset();
      give_verdict();
   end
endmodule
